// file: hw/ddff_pkg.sv
// ==========================================================================
// Shared constants of the dual data flip-flop block.
// ==========================================================================
package ddff_pkg;

  // Number of independent storage cells.
  localparam int unsigned NUM_CELLS = 2;

  // Value of each stored bit after the system reset.
  localparam logic STATE_RST = 1'b0;

  // Remembered level of the effective clock after the system reset.
  // Taken as high so that a clock already high at release is not seen as an edge.
  localparam logic PREV_CLK_RST = 1'b1;

  // Value of the conflict flag after the system reset.
  localparam logic CONFLICT_RST = 1'b0;

endpackage

// file: hw/ddff_edge.sv
`timescale 1ns/1ns
// ==========================================================================
// Rising edge finder for the sampled effective clock of every cell.
// ==========================================================================
module ddff_edge
#(
  parameter int unsigned WIDTH = ddff_pkg::NUM_CELLS
)
(
  input  wire logic             clock_i, // System clock
  input  wire logic             rstn_i,  // Asynchronous reset, active low
  input  wire logic [WIDTH-1:0] level_i, // Sampled effective clock levels
  output logic      [WIDTH-1:0] rise_o   // High where the level went low to high
);

  typedef struct packed
  {
    logic [WIDTH-1:0] prev;
  } ddff_edge_s;

  ddff_edge_s state_ff;
  ddff_edge_s nxt_state;

  // ==========================================================================
  // Next state.
  // ==========================================================================
  always_comb
  begin
    nxt_state      = state_ff;
    nxt_state.prev = level_i;
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_ff.prev <= {WIDTH{ddff_pkg::PREV_CLK_RST}};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================================
  // Edge output.
  // ==========================================================================
  // A level that stays high yields no edge, so data moving during a long
  // high phase cannot reach the stored state.
  assign rise_o = level_i & ~state_ff.prev;

endmodule

// file: hw/ddff_core.sv
`timescale 1ns/1ns
// Contract
// - Two independent cells, each with data, set, reset, enable; one shared clock.
// - Set alone drives state high, reset alone drives it low, both together hold.
// - Set and reset override the shared clock and the enable inputs.
// - A cell's effective clock is shared clock OR its own enable.
// - On a rising effective clock the cell loads data; otherwise it holds.
// - Clocked changes of the outputs happen only at the effective rising edge.
// - Data changes away from the rising edge never alter the outputs.
// - Inputs other than the system clock and reset read as low when left open and need no tie-off.
module ddff_core
#(
  parameter int unsigned NUM_CELLS = ddff_pkg::NUM_CELLS
)
(
  input  wire logic                 clock_i,             // System clock, 125 MHz
  input  wire logic                 rstn_i,              // Asynchronous reset, active low
  input  wire logic                 shared_clock_i = '0, // Clock common to all cells
  input  wire logic [NUM_CELLS-1:0] clk_enable_i = '0,   // Per-cell clock enable
  input  wire logic [NUM_CELLS-1:0] data_i = '0,         // Per-cell data input
  input  wire logic [NUM_CELLS-1:0] set_i = '0,          // Per-cell set, active high
  input  wire logic [NUM_CELLS-1:0] clear_i = '0,        // Per-cell reset, active high
  output logic      [NUM_CELLS-1:0] q_o,                 // Stored state
  output logic      [NUM_CELLS-1:0] q_n_o,               // Complement of stored state
  output logic      [NUM_CELLS-1:0] conflict_o           // Set and reset seen together
);

  // ==========================================================================
  // Parameter check.
  // ==========================================================================
  if (NUM_CELLS < 1)
  begin : g_bad_cells
    $error("ddff_core needs at least one cell");
  end

  // ==========================================================================
  // State.
  // ==========================================================================
  typedef struct packed
  {
    logic [NUM_CELLS-1:0] q;
    logic [NUM_CELLS-1:0] q_n;
    logic [NUM_CELLS-1:0] conflict;
  } ddff_core_s;

  ddff_core_s           state_ff;
  ddff_core_s           nxt_state;
  logic [NUM_CELLS-1:0] eff_clock;
  logic [NUM_CELLS-1:0] eff_rise;

  // ==========================================================================
  // Effective clock and its rising edge.
  // ==========================================================================
  // The effective clock is an ordinary sampled level: the pins are synchronous
  // to the system clock, so no cell ever runs on a derived clock.
  assign eff_clock = {NUM_CELLS{shared_clock_i}} | clk_enable_i;

  ddff_edge
  #(
    .WIDTH (NUM_CELLS)
  )
  u_edge
  (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .level_i (eff_clock),
    .rise_o  (eff_rise)
  );

  // ==========================================================================
  // Next state, one lane per cell.
  // ==========================================================================
  always_comb
  begin
    nxt_state = state_ff;
    for (int i = 0; i < NUM_CELLS; i++)
    begin
      // Forcing inputs win over any clock activity in the same cycle.
      if (set_i[i] && clear_i[i])
      begin
        // Undefined combination: the state is held and flagged instead of
        // inventing a value, which keeps the outputs deterministic.
        nxt_state.conflict[i] = 1'b1;
      end
      else if (set_i[i])
      begin
        nxt_state.q[i] = 1'b1;
      end
      else if (clear_i[i])
      begin
        nxt_state.q[i] = 1'b0;
      end
      else if (eff_rise[i])
      begin
        nxt_state.q[i] = data_i[i];
      end
      if (!(set_i[i] && clear_i[i]))
      begin
        nxt_state.conflict[i] = 1'b0;
      end
      nxt_state.q_n[i] = ~nxt_state.q[i];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_ff.q        <= {NUM_CELLS{ddff_pkg::STATE_RST}};
      state_ff.q_n      <= {NUM_CELLS{~ddff_pkg::STATE_RST}};
      state_ff.conflict <= {NUM_CELLS{ddff_pkg::CONFLICT_RST}};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Open inputs other than clock_i and rstn_i default to low through the port defaults above.
  assign q_o        = state_ff.q;
  assign q_n_o      = state_ff.q_n;
  assign conflict_o = state_ff.conflict;

  // ==========================================================================
  // Checks, one set per cell.
  // ==========================================================================
  for (genvar g = 0; g < NUM_CELLS; g++)
  begin : g_chk

    sequence s_set_only;
      set_i[g] && !clear_i[g];
    endsequence

    sequence s_clear_only;
      clear_i[g] && !set_i[g];
    endsequence

    sequence s_quiet;
      !set_i[g] && !clear_i[g];
    endsequence

    sequence s_clock_low_then_high;
      !eff_clock[g] ##1 eff_clock[g];
    endsequence

    sequence s_clock_held_high;
      eff_clock[g] [*2];
    endsequence

    a_set_forces_high: assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      s_set_only |=> q_o[g] && !q_n_o[g])
    else $error("set did not drive the cell high");

    a_clear_forces_low: assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      s_clear_only |=> !q_o[g] && q_n_o[g])
    else $error("reset did not drive the cell low");

    a_force_beats_clock: assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      (s_clock_low_then_high ##0 s_set_only) |=> q_o[g] == 1'b1)
    else $error("clock edge overrode set");

    a_edge_loads_data: assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      (s_clock_low_then_high ##0 s_quiet) |=> q_o[g] == $past(data_i[g]))
    else $error("rising effective clock did not load data");

    // The edge finder starts from a high level after reset, so the first
    // cycle after release can never count as an edge.
    a_or_of_clocks: assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      ($rose(clk_enable_i[g]) && !shared_clock_i && !$past(shared_clock_i) && $past(rstn_i)
       && !set_i[g] && !clear_i[g]) |=> q_o[g] == $past(data_i[g]))
    else $error("enable pulse alone did not clock the cell");

    a_no_edge_holds: assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      (s_quiet and !eff_clock[g]) |=> $stable(q_o[g]))
    else $error("state moved with the effective clock low");

    a_high_ignores_data: assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      (s_clock_held_high and s_quiet [*2]) |=> $stable(q_o[g]))
    else $error("data change during high clock altered the state");

    a_conflict_holds: assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      (set_i[g] && clear_i[g]) |=> conflict_o[g] && $stable(q_o[g]))
    else $error("set with reset was not held and flagged");

    a_outputs_paired: assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      q_n_o[g] == ~q_o[g])
    else $error("complement output disagrees with the state");

  end

endmodule

// file: tb/ddff_drv.sv
`timescale 1ns/1ns
// ==========================================================================
// Surrounding clock logic: only one clock source is active at a time.
// ==========================================================================
module ddff_drv
(
  input  wire logic [1:0]                     mode_i,   // 0 idle, 1 shared, 2 enables
  input  wire logic [ddff_pkg::NUM_CELLS-1:0] sel_i,    // Cells clocked by their enable
  output logic                                shared_o, // Shared clock level
  output logic      [ddff_pkg::NUM_CELLS-1:0] enable_o  // Per-cell enable levels
);
  // The enables stay low whenever the shared clock is used, so the OR passes it unchanged.
  assign shared_o = (mode_i == 2'h1);
  // The shared clock stays low while cells are clocked one at a time.
  assign enable_o = (mode_i == 2'h2) ? sel_i : '0;
endmodule

// file: tb/dual_edge_d_flip_flop_test.sv
`timescale 1ns/1ns
module dual_edge_d_flip_flop_test;
  localparam int unsigned N = ddff_pkg::NUM_CELLS;
  logic         clock_i    = 1'b0;
  logic         rstn_i     = 1'b0;
  logic [1:0]   mode       = 2'h0;
  logic [N-1:0] sel        = '0;
  logic [N-1:0] data       = '0;
  logic [N-1:0] set        = '0;
  logic [N-1:0] clr        = '0;
  logic         shared;
  logic [N-1:0] enable;
  logic [N-1:0] q;
  logic [N-1:0] q_n;
  logic [N-1:0] conflict;
  int           fail_count = 0;
  int           n_tests    = 0;

  always #4 clock_i = ~clock_i;

  ddff_drv partner (.mode_i(mode), .sel_i(sel), .shared_o(shared), .enable_o(enable));

  ddff_core #(.NUM_CELLS(N)) DUT (.clock_i(clock_i), .rstn_i(rstn_i), .shared_clock_i(shared),
    .clk_enable_i(enable), .data_i(data), .set_i(set), .clear_i(clr), .q_o(q), .q_n_o(q_n),
    .conflict_o(conflict));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input logic [N-1:0] seen, input logic [N-1:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Inputs change at a falling edge and are judged one falling edge later.
  task automatic step(input logic [1:0] m, input logic [N-1:0] s, input logic [N-1:0] d,
                      input logic [N-1:0] st, input logic [N-1:0] cl);
    mode = m;
    sel  = s;
    data = d;
    set  = st;
    clr  = cl;
    @(negedge clock_i);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_set_clear();
    step(2'h0, 2'h0, 2'h0, 2'h1, 2'h0);
    chk(q, 2'h1);
    chk(q_n, 2'h2);
    step(2'h0, 2'h0, 2'h0, 2'h2, 2'h1);
    chk(q, 2'h2);
    step(2'h0, 2'h0, 2'h3, 2'h0, 2'h0);
    chk(q, 2'h2);
  endtask

  task automatic t_shared();
    step(2'h0, 2'h0, 2'h1, 2'h0, 2'h0);
    step(2'h1, 2'h0, 2'h1, 2'h0, 2'h0);
    chk(q, 2'h1);
    step(2'h1, 2'h0, 2'h2, 2'h0, 2'h0);
    chk(q, 2'h1);
    step(2'h0, 2'h0, 2'h2, 2'h0, 2'h0);
    chk(q, 2'h1);
    step(2'h1, 2'h0, 2'h2, 2'h0, 2'h0);
    chk(q, 2'h2);
  endtask

  // Data of the idle cell differs from its state, so a stray load shows.
  task automatic t_enable();
    step(2'h0, 2'h0, 2'h1, 2'h0, 2'h0);
    step(2'h2, 2'h1, 2'h1, 2'h0, 2'h0);
    chk(q, 2'h3);
    step(2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
    step(2'h2, 2'h2, 2'h0, 2'h0, 2'h0);
    chk(q, 2'h1);
  endtask

  task automatic t_override();
    step(2'h0, 2'h0, 2'h1, 2'h0, 2'h0);
    step(2'h1, 2'h0, 2'h1, 2'h2, 2'h1);
    chk(q, 2'h2);
    step(2'h0, 2'h0, 2'h1, 2'h0, 2'h0);
    chk(q, 2'h2);
  endtask

  // Set and reset together are raised on purpose here; the state must hold.
  task automatic t_conflict();
    step(2'h0, 2'h0, 2'h0, 2'h1, 2'h1);
    chk(q, 2'h2);
    chk(conflict, 2'h1);
    step(2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
    chk(conflict, 2'h0);
  endtask

  // A clock held high across a mid-run reset must not load at release.
  task automatic t_reset_mid();
    step(2'h1, 2'h0, 2'h3, 2'h0, 2'h0);
    chk(q, 2'h3);
    rstn_i = 1'b0;
    @(negedge clock_i);
    chk(q, 2'h0);
    chk(q_n, 2'h3);
    chk(conflict, 2'h0);
    rstn_i = 1'b1;
    @(negedge clock_i);
    chk(q, 2'h0);
    step(2'h0, 2'h0, 2'h3, 2'h0, 2'h0);
    step(2'h1, 2'h0, 2'h3, 2'h0, 2'h0);
    chk(q, 2'h3);
  endtask

  initial
  begin
    repeat (16) @(posedge clock_i);
    @(negedge clock_i);
    chk(q, 2'h0);
    chk(q_n, 2'h3);
    rstn_i = 1'b1;
    @(negedge clock_i);
    t_set_clear();
    t_shared();
    t_enable();
    t_override();
    t_conflict();
    t_reset_mid();
    end_of_test();
  end
endmodule
